// *** ifb_pkg.sv ***
// package: register map, bit masks and carriers for the interrupt flag/enable bank
package ifb_pkg;

    // register word width
    localparam int IFB_DW = 16;
    localparam int IFB_AW = 4;

    // register offsets (word index on the plain port)
    localparam logic [3:0] IFB_OFF_FLAGS_2   = 4'h0;
    localparam logic [3:0] IFB_OFF_FLAGS_3   = 4'h1;
    localparam logic [3:0] IFB_OFF_FLAGS_4   = 4'h2;
    localparam logic [3:0] IFB_OFF_FLAGS_5   = 4'h3;
    localparam logic [3:0] IFB_OFF_ENABLES_0 = 4'h4;
    localparam logic [3:0] IFB_OFF_FLAGS_0   = 4'h5;
    localparam logic [3:0] IFB_OFF_PENDING   = 4'h6;

    // implemented-bit masks; zero bits ignore writes and read as zero
    localparam logic [15:0] IFB_MASK_FLAGS_2   = 16'h3fe3;
    localparam logic [15:0] IFB_MASK_FLAGS_3   = 16'h4066;
    localparam logic [15:0] IFB_MASK_FLAGS_4   = 16'h210e;
    localparam logic [15:0] IFB_MASK_FLAGS_5   = 16'h3ffe;
    localparam logic [15:0] IFB_MASK_ENABLES_0 = 16'h3fef;

    // reset value of every implemented bit
    localparam logic [15:0] IFB_RST_WORD = 16'h0000;

    // flag register 2 field positions
    localparam int IFB_F2_PARALLEL_PORT = 13;
    localparam int IFB_F2_COMPARE8      = 12;
    localparam int IFB_F2_COMPARE5      = 9;
    localparam int IFB_F2_CAPTURE6      = 8;
    localparam int IFB_F2_CAPTURE3      = 5;
    localparam int IFB_F2_SPI_B_EVENT   = 1;
    localparam int IFB_F2_SPI_B_FAULT   = 0;
    // flag register 3 field positions
    localparam int IFB_F3_CALENDAR      = 14;
    localparam int IFB_F3_EXT_IRQ4      = 6;
    localparam int IFB_F3_EXT_IRQ3      = 5;
    localparam int IFB_F3_I2C_B_MASTER  = 2;
    localparam int IFB_F3_I2C_B_SLAVE   = 1;
    // flag register 4 field positions
    localparam int IFB_F4_CHARGE_TIME   = 13;
    localparam int IFB_F4_LOW_VOLTAGE   = 8;
    localparam int IFB_F4_CHECKSUM_GEN  = 3;
    localparam int IFB_F4_UART_B_ERROR  = 2;
    localparam int IFB_F4_UART_A_ERROR  = 1;
    // flag register 5 field positions
    localparam int IFB_F5_CAPTURE9      = 13;
    localparam int IFB_F5_COMPARE9      = 12;
    localparam int IFB_F5_SPI_C_EVENT   = 11;
    localparam int IFB_F5_SPI_C_FAULT   = 10;
    localparam int IFB_F5_UART_D_TX     = 9;
    localparam int IFB_F5_UART_D_RX     = 8;
    localparam int IFB_F5_UART_D_ERROR  = 7;
    localparam int IFB_F5_OTG_MODULE    = 6;
    localparam int IFB_F5_I2C_C_MASTER  = 5;
    localparam int IFB_F5_I2C_C_SLAVE   = 4;
    localparam int IFB_F5_UART_C_TX     = 3;
    localparam int IFB_F5_UART_C_RX     = 2;
    localparam int IFB_F5_UART_C_ERROR  = 1;
    // enable register 0 field positions, same as flag register 0
    localparam int IFB_E0_CONVERSION    = 13;
    localparam int IFB_E0_UART_A_TX     = 12;
    localparam int IFB_E0_UART_A_RX     = 11;
    localparam int IFB_E0_SPI_A_DONE    = 10;
    localparam int IFB_E0_SPI_A_FAULT   = 9;
    localparam int IFB_E0_TIMER_C       = 8;
    localparam int IFB_E0_TIMER_B       = 7;
    localparam int IFB_E0_COMPARE2      = 6;
    localparam int IFB_E0_CAPTURE2      = 5;
    localparam int IFB_E0_TIMER_A       = 3;
    localparam int IFB_E0_COMPARE1      = 2;
    localparam int IFB_E0_CAPTURE1      = 1;
    localparam int IFB_E0_EXT_IRQ0      = 0;

    // register port request
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } ifb_req_s;

    // event pulses from the sources, one word per flag register
    typedef struct packed {
        logic [15:0] flags_2;
        logic [15:0] flags_3;
        logic [15:0] flags_4;
        logic [15:0] flags_5;
    } ifb_events_s;

endpackage

// *** ifb_bank.sv ***
// interrupt request flag registers 2..5 and enable register 0
`timescale 1ns/1ns

module ifb_bank (
    // clock, reset, enable
    input  wire logic                ref_clk_in,
    input  wire logic                sys_rst_in,
    input  wire logic                clk_en_in,
    // register port
    input  wire ifb_pkg::ifb_req_s   req_in,
    output logic [15:0]              rdata_out,
    // peripheral event pulses for flag registers 2..5
    input  wire ifb_pkg::ifb_events_s events_in,
    // flag register 0 word from the neighbouring bank
    input  wire logic [15:0]         flags_0_in,
    // request lines toward the core
    output logic [15:0]              pending_0_out,
    output logic                     irq_any_out
);
    import ifb_pkg::*;

    logic [15:0] flags_2;
    logic [15:0] flags_3;
    logic [15:0] flags_4;
    logic [15:0] flags_5;
    logic [15:0] enables_0;
    logic [15:0] pending_0;
    logic [15:0] next_rdata;

    // write decode, one strobe per register
    logic wr_f2;
    logic wr_f3;
    logic wr_f4;
    logic wr_f5;
    logic wr_e0;
    assign wr_f2 = req_in.wr && (req_in.addr == IFB_OFF_FLAGS_2);
    assign wr_f3 = req_in.wr && (req_in.addr == IFB_OFF_FLAGS_3);
    assign wr_f4 = req_in.wr && (req_in.addr == IFB_OFF_FLAGS_4);
    assign wr_f5 = req_in.wr && (req_in.addr == IFB_OFF_FLAGS_5);
    assign wr_e0 = req_in.wr && (req_in.addr == IFB_OFF_ENABLES_0);

    // sticky flag update: write value, then events or'd on top so a set beats a clear
    function automatic logic [15:0] flag_next(input logic [15:0] cur, input logic wr,
                                              input logic [15:0] wdata, input logic [15:0] ev,
                                              input logic [15:0] mask);
        logic [15:0] base;
        base = wr ? wdata : cur;
        return (base | ev) & mask;
    endfunction

    // flag register 2: parallel port, compare 8..5, capture 6..3, second spi
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            flags_2 <= IFB_RST_WORD;
        end else if (clk_en_in) begin
            flags_2 <= flag_next(flags_2, wr_f2, req_in.wdata, events_in.flags_2,
                                 IFB_MASK_FLAGS_2);
        end
    end

    // flag register 3: calendar, external irq 4/3, second i2c
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            flags_3 <= IFB_RST_WORD;
        end else if (clk_en_in) begin
            flags_3 <= flag_next(flags_3, wr_f3, req_in.wdata, events_in.flags_3,
                                 IFB_MASK_FLAGS_3);
        end
    end

    // flag register 4: charge time, low voltage, checksum, uart errors
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            flags_4 <= IFB_RST_WORD;
        end else if (clk_en_in) begin
            flags_4 <= flag_next(flags_4, wr_f4, req_in.wdata, events_in.flags_4,
                                 IFB_MASK_FLAGS_4);
        end
    end

    // flag register 5: capture/compare 9, third spi, uarts c/d, otg, third i2c
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            flags_5 <= IFB_RST_WORD;
        end else if (clk_en_in) begin
            flags_5 <= flag_next(flags_5, wr_f5, req_in.wdata, events_in.flags_5,
                                 IFB_MASK_FLAGS_5);
        end
    end

    // enable register 0, plain software storage
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            enables_0 <= IFB_RST_WORD;
        end else if (clk_en_in && wr_e0) begin
            enables_0 <= req_in.wdata & IFB_MASK_ENABLES_0;
        end
    end

    // gate flag register 0 by its enables, bit for bit
    genvar gi;
    generate
        for (gi = 0; gi < IFB_DW; gi++) begin : g_gate
            assign pending_0[gi] = flags_0_in[gi] & enables_0[gi];
        end
    endgenerate

    // request lines to the core
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            pending_0_out <= 16'h0000;
            irq_any_out   <= 1'b0;
        end else if (clk_en_in) begin
            pending_0_out <= pending_0;
            irq_any_out   <= |pending_0;
        end
    end

    // read mux; unmapped addresses return zero
    always_comb begin
        case (req_in.addr)
            IFB_OFF_FLAGS_2:   next_rdata = flags_2;
            IFB_OFF_FLAGS_3:   next_rdata = flags_3;
            IFB_OFF_FLAGS_4:   next_rdata = flags_4;
            IFB_OFF_FLAGS_5:   next_rdata = flags_5;
            IFB_OFF_ENABLES_0: next_rdata = enables_0;
            IFB_OFF_FLAGS_0:   next_rdata = flags_0_in & IFB_MASK_ENABLES_0;
            IFB_OFF_PENDING:   next_rdata = pending_0;
            default:           next_rdata = 16'h0000;
        endcase
    end

    // read data stands only in the cycle after the read strobe
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            rdata_out <= 16'h0000;
        end else if (clk_en_in) begin
            rdata_out <= req_in.rd ? next_rdata : 16'h0000;
        end
    end

    // flag that was set stays set until written
    property p_flag_sticky;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (clk_en_in && flags_2[IFB_F2_PARALLEL_PORT] && !wr_f2) |=> flags_2[IFB_F2_PARALLEL_PORT];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost without write");

    // event beats same-cycle clear
    property p_set_wins;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (clk_en_in && events_in.flags_5[IFB_F5_UART_D_TX]) |=> flags_5[IFB_F5_UART_D_TX];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost");

    // unimplemented bits stay zero
    property p_unused_zero;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        ((flags_2 & ~IFB_MASK_FLAGS_2) == 16'h0000) && ((flags_3 & ~IFB_MASK_FLAGS_3) == 16'h0000)
        && ((flags_4 & ~IFB_MASK_FLAGS_4) == 16'h0000) && ((enables_0 & ~IFB_MASK_ENABLES_0) == 16'h0000)
        && ((flags_5 & ~IFB_MASK_FLAGS_5) == 16'h0000);
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unimplemented bit set");

    // software clear without event takes effect next cycle
    property p_clear;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (clk_en_in && wr_f3 && !req_in.wdata[IFB_F3_CALENDAR] && !events_in.flags_3[IFB_F3_CALENDAR])
        |=> !flags_3[IFB_F3_CALENDAR];
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared");

    // pending output follows flag and enable
    property p_pending;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        clk_en_in |=> (pending_0_out == ($past(flags_0_in) & $past(enables_0)));
    endproperty
    a_pending: assert property (p_pending) else $error("pending mismatch");

    // enable write lands masked
    property p_enable_write;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (clk_en_in && wr_e0) |=> (enables_0 == ($past(req_in.wdata) & IFB_MASK_ENABLES_0));
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable write wrong");

    // read returns flag register 4 one cycle later
    property p_read4;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (clk_en_in && req_in.rd && req_in.addr == IFB_OFF_FLAGS_4 && !req_in.wr)
        |=> (rdata_out == $past(flags_4));
    endproperty
    a_read4: assert property (p_read4) else $error("read data wrong");

    // any-request line only with an enabled flag
    property p_irq_any;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        irq_any_out |-> (pending_0_out != 16'h0000);
    endproperty
    a_irq_any: assert property (p_irq_any) else $error("spurious request");

    // per-bit flag checks: an event sets its flag, a set flag holds until written
    genvar gb;
    generate
        for (gb = 0; gb < IFB_DW; gb++) begin : g_flag_chk
            property p_set_2;
                @(posedge ref_clk_in) disable iff (sys_rst_in)
                (clk_en_in && IFB_MASK_FLAGS_2[gb] && events_in.flags_2[gb]) |=> flags_2[gb];
            endproperty
            a_set_2: assert property (p_set_2) else $error("flag 2 event lost");

            property p_set_3;
                @(posedge ref_clk_in) disable iff (sys_rst_in)
                (clk_en_in && IFB_MASK_FLAGS_3[gb] && events_in.flags_3[gb]) |=> flags_3[gb];
            endproperty
            a_set_3: assert property (p_set_3) else $error("flag 3 event lost");

            property p_set_4;
                @(posedge ref_clk_in) disable iff (sys_rst_in)
                (clk_en_in && IFB_MASK_FLAGS_4[gb] && events_in.flags_4[gb]) |=> flags_4[gb];
            endproperty
            a_set_4: assert property (p_set_4) else $error("flag 4 event lost");

            property p_set_5;
                @(posedge ref_clk_in) disable iff (sys_rst_in)
                (clk_en_in && IFB_MASK_FLAGS_5[gb] && events_in.flags_5[gb]) |=> flags_5[gb];
            endproperty
            a_set_5: assert property (p_set_5) else $error("flag 5 event lost");

            property p_hold_2;
                @(posedge ref_clk_in) disable iff (sys_rst_in)
                (clk_en_in && flags_2[gb] && !wr_f2) |=> flags_2[gb];
            endproperty
            a_hold_2: assert property (p_hold_2) else $error("flag 2 dropped without write");

            property p_hold_3;
                @(posedge ref_clk_in) disable iff (sys_rst_in)
                (clk_en_in && flags_3[gb] && !wr_f3) |=> flags_3[gb];
            endproperty
            a_hold_3: assert property (p_hold_3) else $error("flag 3 dropped without write");

            property p_hold_4;
                @(posedge ref_clk_in) disable iff (sys_rst_in)
                (clk_en_in && flags_4[gb] && !wr_f4) |=> flags_4[gb];
            endproperty
            a_hold_4: assert property (p_hold_4) else $error("flag 4 dropped without write");

            property p_hold_5;
                @(posedge ref_clk_in) disable iff (sys_rst_in)
                (clk_en_in && flags_5[gb] && !wr_f5) |=> flags_5[gb];
            endproperty
            a_hold_5: assert property (p_hold_5) else $error("flag 5 dropped without write");
        end
    endgenerate

    // write to flag word 2 lands masked, same-cycle events on top
    property p_write_2;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (clk_en_in && wr_f2)
        |=> (flags_2 == (($past(req_in.wdata) | $past(events_in.flags_2)) & IFB_MASK_FLAGS_2));
    endproperty
    a_write_2: assert property (p_write_2) else $error("flag 2 write wrong");

    // write to flag word 3 lands masked, same-cycle events on top
    property p_write_3;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (clk_en_in && wr_f3)
        |=> (flags_3 == (($past(req_in.wdata) | $past(events_in.flags_3)) & IFB_MASK_FLAGS_3));
    endproperty
    a_write_3: assert property (p_write_3) else $error("flag 3 write wrong");

    // write to flag word 4 lands masked, same-cycle events on top
    property p_write_4;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (clk_en_in && wr_f4)
        |=> (flags_4 == (($past(req_in.wdata) | $past(events_in.flags_4)) & IFB_MASK_FLAGS_4));
    endproperty
    a_write_4: assert property (p_write_4) else $error("flag 4 write wrong");

    // write to flag word 5 lands masked, same-cycle events on top
    property p_write_5;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (clk_en_in && wr_f5)
        |=> (flags_5 == (($past(req_in.wdata) | $past(events_in.flags_5)) & IFB_MASK_FLAGS_5));
    endproperty
    a_write_5: assert property (p_write_5) else $error("flag 5 write wrong");

    // read data fall back to zero when no read was asked
    property p_rdata_idle;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (clk_en_in && !req_in.rd) |=> (rdata_out == 16'h0000);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outlived its cycle");

    // low clock enable freezes every register checked here; irq_any_out is left out of this check
    property p_freeze;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        !clk_en_in |=> ($stable(flags_2) && $stable(flags_3) && $stable(flags_4) && $stable(flags_5)
                        && $stable(enables_0) && $stable(rdata_out) && $stable(pending_0_out));
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");

    // read of the enable word
    property p_read_en;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (clk_en_in && req_in.rd && req_in.addr == IFB_OFF_ENABLES_0)
        |=> (rdata_out == $past(enables_0));
    endproperty
    a_read_en: assert property (p_read_en) else $error("enable read wrong");

    // read of flag word 3
    property p_read3;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (clk_en_in && req_in.rd && req_in.addr == IFB_OFF_FLAGS_3)
        |=> (rdata_out == $past(flags_3));
    endproperty
    a_read3: assert property (p_read3) else $error("flag 3 read wrong");

    // read of the flag register 0 mirror, enable positions only
    property p_read_mirror;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (clk_en_in && req_in.rd && req_in.addr == IFB_OFF_FLAGS_0)
        |=> (rdata_out == ($past(flags_0_in) & IFB_MASK_ENABLES_0));
    endproperty
    a_read_mirror: assert property (p_read_mirror) else $error("mirror read wrong");

    // read of the gated pending word
    property p_read_pending;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (clk_en_in && req_in.rd && req_in.addr == IFB_OFF_PENDING)
        |=> (rdata_out == ($past(flags_0_in) & $past(enables_0)));
    endproperty
    a_read_pending: assert property (p_read_pending) else $error("pending read wrong");

    // unmapped addresses read zero
    property p_read_unmapped;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (clk_en_in && req_in.rd && req_in.addr > IFB_OFF_PENDING) |=> (rdata_out == 16'h0000);
    endproperty
    a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not zero");

    // any-request line follows the gated word
    property p_irq_follow;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        clk_en_in |=> (irq_any_out == ($past(pending_0) != 16'h0000));
    endproperty
    a_irq_follow: assert property (p_irq_follow) else $error("request line wrong");

    // main scenarios
    c_set_clear: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        flags_2[IFB_F2_SPI_B_FAULT] ##1 !flags_2[IFB_F2_SPI_B_FAULT]);
    c_collide: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        clk_en_in && wr_f5 && events_in.flags_5 != 16'h0000);
    c_irq: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in) irq_any_out);
    c_freeze: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in) !clk_en_in && wr_e0);
    c_unmapped: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        clk_en_in && req_in.rd && req_in.addr > IFB_OFF_PENDING);

endmodule // ifb_bank

// *** ifb_src_model.sv ***
// peripheral event source model: event pulses lasting as many cycles as fire_in is held, and flag register 0 level
`timescale 1ns/1ns
module ifb_src_model (
    // clock
    input  wire logic                 ref_clk_in,
    // stimulus from the bench
    input  wire logic                 fire_in,
    input  wire ifb_pkg::ifb_events_s word_in,
    input  wire logic [15:0]          flags_0_lvl_in,
    // toward the bank
    output ifb_pkg::ifb_events_s      events_out,
    output logic [15:0]               flags_0_out
);
    import ifb_pkg::*;
    // events drop to zero outside a pulse, never hold the last word
    always_ff @(posedge ref_clk_in) begin
        events_out <= fire_in ? word_in : '0;
    end
    // flag register 0 word is a plain level from the neighbouring bank
    always_ff @(posedge ref_clk_in) begin
        flags_0_out <= flags_0_lvl_in;
    end
endmodule // ifb_src_model

// *** testbench.sv ***
// self-checking bench for the interrupt flag and enable bank
`timescale 1ns/1ns
module testbench;
    import ifb_pkg::*;
    logic        ref_clk_in;
    logic        sys_rst_in;
    logic        clk_en;
    ifb_req_s    req;
    logic [15:0] rdata;
    ifb_events_s ev_word;
    ifb_events_s events;
    logic        fire;
    logic [15:0] f0_lvl;
    logic [15:0] f0;
    logic [15:0] pending;
    logic        irq_any;
    logic [15:0] exp_reg [0:4];
    logic [15:0] w;
    int          n_mismatch;
    int          checks_done;
    int          seed;

    ifb_bank u_ifb_bank (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en),
        .req_in(req), .rdata_out(rdata), .events_in(events), .flags_0_in(f0),
        .pending_0_out(pending), .irq_any_out(irq_any));
    ifb_src_model u_ifb_src_model (.ref_clk_in(ref_clk_in), .fire_in(fire), .word_in(ev_word),
        .flags_0_lvl_in(f0_lvl), .events_out(events), .flags_0_out(f0));

    // implemented bits of each word, zero for unmapped places
    function automatic logic [15:0] mask_of(input int a);
        case (a)
            0: return IFB_MASK_FLAGS_2;
            1: return IFB_MASK_FLAGS_3;
            2: return IFB_MASK_FLAGS_4;
            3: return IFB_MASK_FLAGS_5;
            4: return IFB_MASK_ENABLES_0;
            default: return 16'h0000;
        endcase
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        if (n_mismatch == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic do_reset;
        sys_rst_in <= 1'b1;
        repeat (8) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        for (int i = 0; i < 5; i++) exp_reg[i] = 16'h0000;
    endtask

    task automatic wr(input int a, input logic [15:0] d);
        @(posedge ref_clk_in);
        req <= '{addr: a[3:0], wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk_in);
        req.wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input int a, input logic [15:0] exp);
        @(posedge ref_clk_in);
        req <= '{addr: a[3:0], wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk_in);
        req.rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic check_all;
        for (int a = 0; a < 5; a++) rd_chk(a, exp_reg[a]);
        rd_chk(7, 16'h0000);
    endtask

    task automatic raise(input ifb_events_s e);
        @(posedge ref_clk_in);
        ev_word <= e;
        fire <= 1'b1;
        @(posedge ref_clk_in);
        fire <= 1'b0;
        exp_reg[0] |= e.flags_2 & mask_of(0);
        exp_reg[1] |= e.flags_3 & mask_of(1);
        exp_reg[2] |= e.flags_4 & mask_of(2);
        exp_reg[3] |= e.flags_5 & mask_of(3);
    endtask

    // free-running clock
    initial begin
        ref_clk_in = 1'b0;
        forever #4 ref_clk_in = ~ref_clk_in;
    end

    // hang guard, well past the expected run length
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        n_mismatch++;
        finish_test;
    end

    // main sequence
    initial begin
        seed = 39206;
        n_mismatch = 0;
        checks_done = 0;
        sys_rst_in = 1'b1;
        req = '0;
        ev_word = '0;
        fire = 1'b0;
        clk_en = 1'b1;
        f0_lvl = 16'h0000;
        do_reset;
        check_all;
        chk(pending, 16'h0000);
        for (int a = 0; a < 8; a++) wr(a, 16'hffff);
        for (int a = 0; a < 5; a++) exp_reg[a] = mask_of(a);
        check_all;
        // read data stand for one cycle only
        rd_chk(3, mask_of(3));
        @(posedge ref_clk_in);
        #1;
        chk(rdata, 16'h0000);
        for (int a = 0; a < 5; a++) wr(a, 16'h0000);
        for (int a = 0; a < 5; a++) exp_reg[a] = 16'h0000;
        check_all;
        repeat (12) begin
            raise({$random(seed), $random(seed)} & {$random(seed), $random(seed)});
            check_all;
        end
        for (int a = 0; a < 5; a++) begin
            w = 16'($random(seed));
            wr(a, w);
            exp_reg[a] = w & mask_of(a);
        end
        check_all;
        // clear write and source event land on the same edge
        wr(0, 16'hffff);
        @(posedge ref_clk_in);
        ev_word <= {16'h2000, 48'h0};
        fire <= 1'b1;
        @(posedge ref_clk_in);
        fire <= 1'b0;
        req <= '{addr: 4'h0, wdata: 16'h0000, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk_in);
        req.wr <= 1'b0;
        rd_chk(0, 16'h2000);
        exp_reg[0] = 16'h2000;
        // clock enable low: a write and a burst of events are both ignored
        @(posedge ref_clk_in);
        clk_en <= 1'b0;
        ev_word <= '1;
        fire <= 1'b1;
        wr(4, 16'hffff);
        fire <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        clk_en <= 1'b1;
        check_all;
        repeat (10) begin
            w = 16'($random(seed));
            @(posedge ref_clk_in);
            f0_lvl <= 16'($random(seed));
            wr(4, w);
            repeat (3) @(posedge ref_clk_in);
            #1;
            chk(pending, f0_lvl & w & mask_of(4));
            chk({15'h0, irq_any}, {15'h0, |(f0_lvl & w & mask_of(4))});
            rd_chk(5, f0_lvl & mask_of(4));
            rd_chk(6, f0_lvl & w & mask_of(4));
        end
        // reset again in mid-run, with enables and flags loaded
        @(posedge ref_clk_in);
        do_reset;
        check_all;
        chk(pending, 16'h0000);
        chk({15'h0, irq_any}, 16'h0000);
        finish_test;
    end
endmodule // testbench
